// ===== dv/plwdt_top_sva.sv
// Checker for the watchdog's register reads and internal reset outputs.
// Assumes it is bound to plwdt_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module plwdt_top_sva
   import plwdt_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB and modes
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              osc_unstoppable,
   input wire logic              bit_access,
   // Reset outputs
   input wire logic              wdt_internal_reset,
   input wire logic              wdt_reset_cause_set
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc, mode_wr, kick_wr, seen, stopped;
   assign acc     = psel && penable;
   assign mode_wr = acc && pwrite && paddr == MODE_ADDR && pstrb[0]
                    && !bit_access;
   assign kick_wr = acc && pwrite && paddr == KICK_ADDR;
   // Suppression depends on the first mode write only, so remember it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen    <= 1'b0;
         stopped <= 1'b0;
      end else if (mode_wr && !seen) begin
         seen    <= 1'b1;
         stopped <= pwdata[CLOCK_STOP_SELECT_BIT] && !osc_unstoppable;
      end
   end
   sequence s_bad_kick;
      kick_wr && (pwdata[7:0] != KICK_KEY || bit_access);
   endsequence
   sequence s_pulse;
      wdt_internal_reset ##1 !wdt_internal_reset;
   endsequence
   chk_cause_pair: assert property (wdt_internal_reset |-> wdt_reset_cause_set)
      else $error("reset cause not flagged");
   chk_pulse_once: assert property (wdt_internal_reset |-> s_pulse)
      else $error("reset pulse too long");
   chk_kick_read: assert property (acc && !pwrite && paddr == KICK_ADDR
      |-> prdata == {24'h0, KICK_RESET}) else $error("kick read wrong");
   chk_mode_top: assert property (acc && !pwrite && paddr == MODE_ADDR
      |-> prdata[31:5] == {24'h0, MODE_TOP}) else $error("mode top bad");
   chk_key_quiet: assert property (kick_wr && pwdata[7:0] == KICK_KEY
      && !bit_access |=> !wdt_internal_reset) else $error("key reset");
   chk_bad_kick: assert property (s_bad_kick ##0 !stopped |=> s_pulse)
      else $error("bad kick gave no reset");
   chk_suppressed: assert property (s_bad_kick ##0 stopped
      |=> !wdt_internal_reset) else $error("stopped wdt reset");
   chk_second_mode: assert property (mode_wr && seen && !stopped
      |=> s_pulse) else $error("second mode write no reset");
   chk_start_quiet: assert property ($rose(presetn)
      |-> !wdt_internal_reset [*8]) else $error("reset after start");
endmodule : plwdt_top_sva
bind plwdt_top plwdt_top_sva plwdt_top_sva_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .osc_unstoppable,
   .bit_access, .wdt_internal_reset, .wdt_reset_cause_set);
`default_nettype wire

// ===== dv/plwdt_top_test.sv
// Self-checking bench for the watchdog: APB tasks and directed tests.
// Assumes the internal reset pulse does not reset the block itself.
`timescale 1ns/1ps
`default_nettype none
module plwdt_top_test;
   import plwdt_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bit_access;
   logic osc_unstoppable, halt_mode, stop_mode, slow_osc_tick, irst, cset;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic [2:0]        div;
   int failures, compares, npulse;
   plwdt_top plwdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .osc_unstoppable(osc_unstoppable), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .osc_settle_done(1'b1),
      .slow_osc_tick(slow_osc_tick), .bit_access(bit_access),
      .wdt_internal_reset(irst), .wdt_reset_cause_set(cset));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Slow oscillator is one tick in eight pclk cycles
   always @(posedge pclk) begin
      div           <= div + 3'h1;
      slow_osc_tick <= (div == 3'h7);
      if (irst === 1'b1) begin
         npulse++;
         check("cause set", 1'b1, cset);
      end
   end
   task automatic test_done;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : check
   task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d,
                      logic b = 1'b0);
      int i;
      @(posedge pclk);
      psel       <= 1'b1;
      pwrite     <= w;
      paddr      <= a;
      pwdata     <= d;
      bit_access <= b;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      check("pready", 1'b1, pready);
      if (pslverr === 1'b1) rd = 32'hFFFFFFFF;
      psel       <= 1'b0;
      penable    <= 1'b0;
      bit_access <= 1'b0;
   endtask : apb
   task automatic run(int n, int exp);
      repeat (n) @(posedge pclk);
      check("reset pulses", exp, npulse);
   endtask : run
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      npulse = 0;
   endtask : do_reset
   initial begin
      {psel, penable, pwrite, bit_access, halt_mode, stop_mode} = '0;
      {osc_unstoppable, slow_osc_tick, div, paddr, pwdata} = '0;
      pstrb = 4'hF;
      failures = 0;
      compares = 0;
      do_reset();
      apb(1'b0, MODE_ADDR, 32'h0);
      check("mode reset", 32'h67, rd);
      apb(1'b0, KICK_ADDR, 32'h0);
      check("kick reset", 32'h9A, rd);
      apb(1'b0, 18'h0, 32'h0);
      check("unmapped", 32'hFFFFFFFF, rd);
      apb(1'b1, KICK_ADDR, 32'h55);
      run(2, 1);
      do_reset();
      apb(1'b1, KICK_ADDR, 32'hAC, 1'b1);
      run(2, 1);
      do_reset();
      apb(1'b1, MODE_ADDR, 32'h68);
      apb(1'b1, MODE_ADDR, 32'h68);
      run(2, 1);
      do_reset();
      apb(1'b1, MODE_ADDR, 32'h70);
      apb(1'b1, MODE_ADDR, 32'h68);
      apb(1'b1, KICK_ADDR, 32'h55);
      apb(1'b1, KICK_ADDR, 32'hAC, 1'b1);
      run(9000, 0);
      do_reset();
      apb(1'b1, MODE_ADDR, 32'h68);
      apb(1'b0, MODE_ADDR, 32'h0);
      check("mode written", 32'h68, rd);
      run(6000, 0);
      apb(1'b1, KICK_ADDR, 32'hAC);
      apb(1'b0, KICK_ADDR, 32'h0);
      check("kick read", 32'h9A, rd);
      run(8100, 0);
      run(200, 1);
      do_reset();
      apb(1'b1, MODE_ADDR, 32'h68);
      run(4000, 0);
      halt_mode <= 1'b1;
      run(6000, 0);
      halt_mode <= 1'b0;
      run(4000, 0);
      run(400, 1);
      osc_unstoppable <= 1'b1;
      do_reset();
      apb(1'b1, MODE_ADDR, 32'h68);
      apb(1'b0, MODE_ADDR, 32'h0);
      check("fixed clock bits", 32'h60, rd);
      stop_mode <= 1'b1;
      run(8000, 0);
      apb(1'b1, KICK_ADDR, 32'hAC);
      run(16000, 0);
      run(800, 1);
      test_done();
   end
   initial begin
      #3600000;
      failures++;
      test_done();
   end
endmodule : plwdt_top_test
`default_nettype wire

// ===== verilog/plwdt_cnt_if.sv
// Interface between the watchdog control core and its counter.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface plwdt_cnt_if;
   logic       tick;
   logic       clear;
   logic [4:0] limit_exp;
   logic       overflow;
   logic [20:0] count;
   modport ctrl (output tick, output clear, output limit_exp,
                 input overflow, input count);
   modport cnt  (input tick, input clear, input limit_exp,
                 output overflow, output count);
endinterface : plwdt_cnt_if
`default_nettype wire

// ===== verilog/plwdt_counter.sv
// Watchdog count register with power-of-two overflow compare.
// Assumes clear is a one-cycle pulse on pclk; tick stays high on the system clock, one count per cycle.
`timescale 1ns/1ps
`default_nettype none
module plwdt_counter
   import plwdt_pkg::*;
(
   // Clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Control side
   plwdt_cnt_if.cnt   cif
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             overflow;
   } plwdt_cnt_t;

   plwdt_cnt_t state;
   plwdt_cnt_t next_state;

   always_comb begin
      next_state = state;
      next_state.overflow = 1'b0;
      if (cif.clear) begin
         next_state.count = '0;
      end else if (cif.tick) begin
         // RL20 power-of-two compare
         if ({1'b0, state.count} + 22'h1 == (22'h1 << cif.limit_exp)) begin
            next_state.overflow = 1'b1;
            next_state.count    = '0;
         end else begin
            next_state.count = state.count + 21'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign cif.overflow = state.overflow;
   assign cif.count    = state.count;
endmodule : plwdt_counter
`default_nettype wire

// ===== verilog/plwdt_pkg.sv
// Package for the program-loop watchdog: register map, reset values,
// field positions and timing constants.
// Assumes a 25 MHz APB clock and byte registers in the low bits of a word.
package plwdt_pkg;
   // Printed offsets are not word multiples: they are indices, byte = 4*index
   localparam logic [15:0] WATCHDOG_MODE_CONTROL_IDX = 16'hFF48;
   localparam logic [15:0] WATCHDOG_KICK_KEY_IDX     = 16'hFF49;
   localparam int          ADDR_W                    = 18;
   localparam logic [17:0] MODE_ADDR = {WATCHDOG_MODE_CONTROL_IDX, 2'b00};
   localparam logic [17:0] KICK_ADDR = {WATCHDOG_KICK_KEY_IDX, 2'b00};
   // Read-only status register: index of own choosing
   localparam logic [15:0] WATCHDOG_STATUS_IDX       = 16'hFF4A;
   localparam logic [17:0] STAT_ADDR = {WATCHDOG_STATUS_IDX, 2'b00};

   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [2:0] MODE_TOP   = 3'h3;
   localparam logic [7:0] KICK_RESET = 8'h9A;
   localparam logic [7:0] KICK_KEY   = 8'hAC;
   localparam int CLOCK_STOP_SELECT_BIT   = 4;
   localparam int CLOCK_SOURCE_SELECT_BIT = 3;
   localparam int STATUS_CAUSE_BIT        = 4;

   // Interval bases: code 0 gives 2^11 slow or 2^13 system cycles
   localparam int SLOW_BASE_EXP = 11;
   localparam int SYS_BASE_EXP  = 13;
   localparam int CNT_W         = 21;

   // Post-STOP settling hold on the system clock
   localparam int CLK_MHZ        = 25;
   localparam int STOP_HOLD_US   = 34;
   localparam int STOP_HOLD_CYC  = STOP_HOLD_US * CLK_MHZ;
   localparam int HOLD_W         = 11;
endpackage : plwdt_pkg

// ===== verilog/plwdt_top.sv
// Program-loop watchdog: APB registers, clock choice, stop handling and
// internal reset generation.
// Assumes slow_osc_tick is a one-cycle enable from an external divider and
// the reset-cause register lives elsewhere, fed by wdt_reset_cause_set.
//
// Operation
// RL1 - Clock bits: 00 slow oscillator, 01 system clock, 1x stops counting.
// RL2 - Interval code n overflows at 2^(11+n) slow or 2^(13+n) system.
// RL3 - Mode resets to 67H; software keeps top bits 011.
// RL4 - After reset count on slow oscillator with longest interval.
// RL5 - Mode register accepts one write; a second write resets the chip.
// RL6 - First write stopping the watchdog suppresses all illegal-access resets.
// RL7 - Software writes the mode register only as a whole byte.
// RL8 - Unstoppable option ignores clock bits, always slow oscillator.
// RL9 - Unstoppable option counts through STOP and resets on overflow.
// RL10 - Writing key ACH to kick register clears the counter.
// RL11 - Kick register resets to 9AH and always reads 9AH.
// RL12 - Writing a non-key value to kick register resets the chip.
// RL13 - Bit-manipulation access to kick register resets the chip.
// RL14 - Writing the mode register clears the counter.
// RL15 - Reaching the selected interval without a kick resets the chip.
// RL16 - Stoppable option freezes count in HALT and STOP, keeps value.
// RL17 - After STOP on system clock hold 34 us plus settling wait.
// RL18 - Software kicks from timer one during STOP when unstoppable.
// RL19 - Watchdog reset flags the reset-cause bit for software.
// RL20 - Counter is 21 bits and compares to the selected power of two.
`timescale 1ns/1ps
`default_nettype none
module plwdt_top
   import plwdt_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic                    pready,
   output logic                    pslverr,
   output logic [31:0]             prdata,
   // Option and power modes
   input  wire logic               osc_unstoppable,
   input  wire logic               halt_mode,
   input  wire logic               stop_mode,
   input  wire logic               osc_settle_done,
   // Count clock and bit-manipulation flag
   input  wire logic               slow_osc_tick,
   input  wire logic               bit_access,
   // Reset outputs
   output logic                    wdt_internal_reset,
   output logic                    wdt_reset_cause_set
);
   // Run states of the count gate; HOLD and SETTLE follow a STOP only
   typedef enum logic [1:0] {
      PLWDT_RUN    = 2'b00,
      PLWDT_FROZEN = 2'b01,
      PLWDT_HOLD   = 2'b10,
      PLWDT_SETTLE = 2'b11
   } plwdt_run_t;

   // Whole state of the control core, registered as one word
   typedef struct packed {
      logic [7:0]        mode;
      logic              mode_written;
      logic              stopped_first;
      plwdt_run_t        run;
      logic [HOLD_W-1:0] hold;
      logic              rst_out;
      logic              cause;
      logic [31:0]       rdata;
   } plwdt_state_t;

   plwdt_state_t state;
   plwdt_state_t next_state;

   // Counter and its compare sit in their own module
   plwdt_cnt_if cif ();

   plwdt_counter u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif.cnt)
   );

   // Field view of the mode register
   logic       clock_stop_select;
   logic       clock_source_select;
   logic       interval_select_msb;
   logic       interval_select_mid;
   logic       interval_select_lsb;
   logic [2:0] interval_code;
   logic [4:0] exp_base;
   // Address decode, shared by the write, read and error paths
   logic       mode_hit;
   logic       kick_hit;
   logic       stat_hit;
   logic       any_hit;
   // Bus phases
   logic       setup;
   logic       access;
   logic       rd_setup;
   // Write strobes
   logic       wr_mode;
   logic       wr_kick;
   logic       full_byte;
   logic       mode_take;
   logic       kick_ok;
   // Illegal-access causes, kept apart so each can be traced
   logic       bad_mode;
   logic       bad_key;
   logic       bad_bit;
   logic       illegal;
   // Counting
   logic       use_sys;
   logic       halted;
   logic       run_ok;
   logic       tick;
   // Read path
   logic [7:0] rd_byte;

   assign clock_stop_select   = state.mode[CLOCK_STOP_SELECT_BIT];
   assign clock_source_select = state.mode[CLOCK_SOURCE_SELECT_BIT];
   assign interval_select_msb = state.mode[2];
   assign interval_select_mid = state.mode[1];
   assign interval_select_lsb = state.mode[0];
   assign interval_code       = {interval_select_msb, interval_select_mid,
                                 interval_select_lsb};

   // The status register is read-only; writes to it are dropped
   assign mode_hit  = (paddr == MODE_ADDR);
   assign kick_hit  = (paddr == KICK_ADDR);
   assign stat_hit  = (paddr == STAT_ADDR);
   assign any_hit   = mode_hit || kick_hit || stat_hit;
   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign rd_setup  = setup && !pwrite;
   // A bit-manipulation cycle never counts as a whole-byte write
   assign full_byte = pstrb[0] && !bit_access;
   assign wr_mode   = access && pwrite && mode_hit;
   assign wr_kick   = access && pwrite && kick_hit;
   // Only the first whole-byte mode write lands; later ones are refused
   assign mode_take = wr_mode && full_byte && !state.mode_written;
   // RL10 key write clears
   assign kick_ok   = wr_kick && full_byte && (pwdata[7:0] == KICK_KEY);

   // RL5 second mode write
   assign bad_mode = wr_mode && state.mode_written;
   // RL12 wrong key
   assign bad_key  = wr_kick && !bit_access && !kick_ok;
   // RL13 bit access to kick
   // Any bit-manipulation cycle on the key register counts, read or write
   assign bad_bit  = access && bit_access && kick_hit;

   always_comb begin
      illegal = bad_mode || bad_key || bad_bit;
      // RL6 suppressed after stop
      // Stopping at the first write is the only way to turn the checks off
      if (state.stopped_first) begin
         illegal = 1'b0;
      end
   end

   // RL8 clock bits ignored
   // RL1 clock selection
   assign use_sys = !osc_unstoppable && clock_source_select;
   assign halted  = !osc_unstoppable && clock_stop_select;

   // RL9 unstoppable never freezes
   // RL16 freeze in HALT and STOP
   always_comb begin
      run_ok = 1'b0;
      if (osc_unstoppable) begin
         // The fixed slow clock keeps counting through HALT and STOP
         run_ok = 1'b1;
      end else if (!halted && state.run == PLWDT_RUN) begin
         run_ok = 1'b1;
      end
   end

   always_comb begin
      tick = 1'b0;
      if (run_ok) begin
         if (use_sys) begin
            tick = 1'b1;
         end else begin
            tick = slow_osc_tick;
         end
      end
   end

   // Read mux; unmapped addresses read zero and raise pslverr instead
   always_comb begin
      rd_byte = 8'h00;
      if (mode_hit) begin
         rd_byte = state.mode;
      end else if (kick_hit) begin
         // RL11 kick reads constant
         rd_byte = KICK_RESET;
      end else if (stat_hit) begin
         rd_byte = {5'h00, state.run, state.mode_written};
      end
   end

   assign cif.tick  = tick;
   // RL14 mode write clears
   // A refused mode write must leave the count alone
   assign cif.clear = mode_take || kick_ok;
   // RL2 interval decode
   // RL4 defaults to longest
   // The system clock base sits two powers above the slow one
   assign exp_base      = use_sys ? 5'(SYS_BASE_EXP) : 5'(SLOW_BASE_EXP);
   assign cif.limit_exp = exp_base + {2'b00, interval_code};

   always_comb begin
      next_state = state;
      next_state.rst_out = 1'b0;
      next_state.cause   = 1'b0;
      // RL3 top bits forced
      // RL8 clock bits ignored when unstoppable
      if (mode_take) begin
         next_state.mode_written  = 1'b1;
         next_state.mode[7:5]     = MODE_TOP;
         next_state.mode[2:0]     = pwdata[2:0];
         if (osc_unstoppable) begin
            // Fixed clock: keep the reset clock choice whatever was written
            next_state.mode[4:3]     = MODE_RESET[4:3];
            next_state.stopped_first = 1'b0;
         end else begin
            next_state.mode[4:3]     = pwdata[4:3];
            next_state.stopped_first = pwdata[CLOCK_STOP_SELECT_BIT];
         end
      end
      // Writes to the status register and to unmapped addresses change
      // nothing; only the error response marks the latter
      // RL16 HALT exits directly
      // RL17 post-STOP hold
      // hold doubles as a marker: nonzero in FROZEN means a STOP was seen,
      // so the exit needs the fixed wait rather than a direct restart
      unique case (state.run)
         PLWDT_RUN: begin
            if (stop_mode) begin
               next_state.run  = PLWDT_FROZEN;
               next_state.hold = HOLD_W'(STOP_HOLD_CYC);
            end else if (halt_mode) begin
               next_state.run  = PLWDT_FROZEN;
               next_state.hold = '0;
            end
         end
         PLWDT_FROZEN: begin
            if (stop_mode) begin
               next_state.hold = HOLD_W'(STOP_HOLD_CYC);
            end else if (halt_mode) begin
               next_state.run = PLWDT_FROZEN;
            end else if (state.hold != '0) begin
               // Leaving STOP: the count stays held for the fixed wait
               next_state.run = PLWDT_HOLD;
            end else begin
               // Leaving HALT: resume at once with the count kept
               next_state.run = PLWDT_RUN;
            end
         end
         PLWDT_HOLD: begin
            if (stop_mode) begin
               next_state.run  = PLWDT_FROZEN;
               next_state.hold = HOLD_W'(STOP_HOLD_CYC);
            end else if (state.hold <= HOLD_W'(1)) begin
               next_state.hold = '0;
               // A crystal on the system clock still has to settle
               if (use_sys) begin
                  next_state.run = PLWDT_SETTLE;
               end else begin
                  next_state.run = PLWDT_RUN;
               end
            end else begin
               next_state.hold = state.hold - HOLD_W'(1);
            end
         end
         PLWDT_SETTLE: begin
            // No time limit here: the oscillator decides how long it takes
            if (stop_mode) begin
               next_state.run  = PLWDT_FROZEN;
               next_state.hold = HOLD_W'(STOP_HOLD_CYC);
            end else if (osc_settle_done) begin
               next_state.run = PLWDT_RUN;
            end
         end
      endcase
      // RL15 overflow reset
      // RL19 cause flag
      // Both pulses come from one flop edge, so the cause register
      // never misses an internal reset
      if (cif.overflow) begin
         next_state.rst_out = 1'b1;
         next_state.cause   = 1'b1;
      end
      if (illegal) begin
         next_state.rst_out = 1'b1;
         next_state.cause   = 1'b1;
      end
      // Read data is captured in the setup cycle so that it stands,
      // registered, through the whole access cycle
      next_state.rdata = 32'h0;
      if (rd_setup) begin
         next_state.rdata = {24'h0, rd_byte};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.mode          <= MODE_RESET;
         state.mode_written  <= 1'b0;
         state.stopped_first <= 1'b0;
         state.run           <= PLWDT_RUN;
         state.hold          <= '0;
         state.rst_out       <= 1'b0;
         state.cause         <= 1'b0;
         state.rdata         <= 32'h0;
      end else begin
         state <= next_state;
      end
   end

   // Every access completes in one cycle, so no wait states
   assign pready  = 1'b1;
   // Unmapped accesses are answered with an error, never dropped silently
   assign pslverr = access && !any_hit;
   assign prdata  = state.rdata;
   assign wdt_internal_reset  = state.rst_out;
   assign wdt_reset_cause_set = state.cause;
endmodule : plwdt_top
`default_nettype wire
